// >>> rtl/fcs_sequencer.sv
// Flash command sequencer with a classic Wishbone slave.
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_sequencer #(
  parameter logic [7:0] MAKER_CODE = 8'h11, // Value is arbitrary.
  parameter logic [7:0] PART_CODE = 8'h22, // Value is arbitrary.
  parameter logic [7:0] MACRO_CODE = 8'h33, // Value is arbitrary.
  parameter int OP_CYCLES = `FCS_OP_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Flash array side.
  input wire logic [31:0] array_data_i,
  output logic [31:0] array_addr_o,
  output logic [31:0] prog_word_o,
  output logic prog_stb_o,
  output logic busy_o,
  output logic [3:0] erase_mask_o,
  output logic [3:0] guard_o,
  output logic fail_i_unused_o
);
  // ************************************************************
  // State.
  // ************************************************************
  fcs_pkg::fcs_reg_t r;
  fcs_pkg::fcs_reg_t next_r;
  logic req;
  logic wr;
  logic [7:0] code;
  logic [7:0] pat;
  logic [1:0] blk;
  logic [1:0] sel2;
  logic in_array;
  logic ctrl_hit;
  // Base of the array, kept whole so that its top bits can be selected.
  localparam logic [31:0] ARRAY_BASE = `FCS_ARRAY_BASE;

  // Decode of the current bus request.
  assign req = cyc_i && stb_i && !r.ack;
  assign wr = req && we_i;
  assign code = dat_i[7:0];
  assign pat = adr_i[`FCS_PAT_MSB:`FCS_PAT_LSB];
  assign sel2 = adr_i[`FCS_SEL_MSB:`FCS_SEL_LSB];
  assign blk = adr_i[`FCS_BLK_LSB+1:`FCS_BLK_LSB];
  assign in_array = (adr_i[31:19] == ARRAY_BASE[31:19]);
  assign ctrl_hit = (adr_i == `FCS_CTRL_ADDR);

  // ************************************************************
  // Sequencer and bus answer.
  // ************************************************************
  // Next state: every state but FCS_BUSY is left to array read on a mismatch.
  always_comb begin
    next_r = r;
    next_r.ack = req;
    next_r.prog_stb = 1'b0;
    next_r.erase_mask = 4'h0;
    if (req && !we_i) begin
      if (ctrl_hit) begin
        next_r.dat = {24'h0, r.guard, 3'h0, r.state != fcs_pkg::FCS_BUSY};
      end else if (r.state == fcs_pkg::FCS_ID) begin
        unique case (r.word_cnt)
          `FCS_ID_MAKER: next_r.dat = {24'h0, MAKER_CODE};
          `FCS_ID_PART: next_r.dat = {24'h0, PART_CODE};
          `FCS_ID_MACRO: next_r.dat = {24'h0, MACRO_CODE};
          default: next_r.dat = 32'h0;
        endcase
      end else begin
        next_r.dat = array_data_i;
      end
    end
    unique case (r.state)
      fcs_pkg::FCS_BUSY: begin
        if (r.op_cnt == 16'h0) begin
          next_r.state = fcs_pkg::FCS_READ;
        end else begin
          next_r.op_cnt = r.op_cnt - 16'h1;
        end
      end
      default: begin
        if (wr) begin
          next_r.state = fcs_pkg::FCS_READ;
          unique case (r.state)
            fcs_pkg::FCS_READ, fcs_pkg::FCS_E4, fcs_pkg::FCS_G4: begin
              if (code == `FCS_CODE_UNLOCK1 && pat == `FCS_PAT_55) begin
                next_r.state = (r.state == fcs_pkg::FCS_READ) ? fcs_pkg::FCS_C2 :
                  (r.state == fcs_pkg::FCS_E4) ? fcs_pkg::FCS_E5 : fcs_pkg::FCS_G5;
              end
            end
            fcs_pkg::FCS_C2: begin
              if (code == `FCS_CODE_UNLOCK2 && pat == `FCS_PAT_AA) begin
                next_r.state = fcs_pkg::FCS_C3;
              end
            end
            fcs_pkg::FCS_C3: begin
              if (pat == `FCS_PAT_55) begin
                unique case (code)
                  `FCS_CODE_IDREAD: next_r.state = fcs_pkg::FCS_ID;
                  `FCS_CODE_PROG: next_r.state = fcs_pkg::FCS_PROG;
                  `FCS_CODE_ERASE: next_r.state = fcs_pkg::FCS_E4;
                  `FCS_CODE_GSET, `FCS_CODE_GCLR: next_r.state = fcs_pkg::FCS_G4;
                  default: next_r.state = fcs_pkg::FCS_READ;
                endcase
                next_r.kind = (code == `FCS_CODE_GSET) ? fcs_pkg::FCS_K_GSET :
                  (code == `FCS_CODE_GCLR) ? fcs_pkg::FCS_K_GCLR : fcs_pkg::FCS_K_ERASE;
                next_r.word_cnt = 2'h0;
              end
            end
            fcs_pkg::FCS_ID: begin
              if (code == `FCS_CODE_IDSEL) begin
                next_r.state = fcs_pkg::FCS_ID;
                next_r.word_cnt = sel2;
              // An unlock pair may start a read/reset from identity mode.
              end else if (code == `FCS_CODE_UNLOCK1 && pat == `FCS_PAT_55) begin
                next_r.state = fcs_pkg::FCS_C2;
              end
            end
            fcs_pkg::FCS_PROG: begin
              if (in_array && r.guard[blk] == 1'b0) begin
                next_r.prog_word = dat_i;
                next_r.prog_stb = 1'b1;
                next_r.word_cnt = r.word_cnt + 2'h1;
                next_r.state = (r.word_cnt == 2'h3) ? fcs_pkg::FCS_BUSY : fcs_pkg::FCS_PROG;
                next_r.op_cnt = OP_CYCLES[15:0];
              end
            end
            fcs_pkg::FCS_E5, fcs_pkg::FCS_G5: begin
              if (code == `FCS_CODE_UNLOCK2 && pat == `FCS_PAT_AA) begin
                next_r.state = (r.state == fcs_pkg::FCS_E5) ? fcs_pkg::FCS_E6 :
                  fcs_pkg::FCS_G6;
              end
            end
            fcs_pkg::FCS_E6: begin
              next_r.op_cnt = OP_CYCLES[15:0];
              if (code == `FCS_CODE_CHIP && pat == `FCS_PAT_55) begin
                next_r.state = fcs_pkg::FCS_BUSY;
                next_r.erase_mask = ~r.guard;
              end else if (code == `FCS_CODE_BLOCK && in_array) begin
                next_r.state = fcs_pkg::FCS_BUSY;
                next_r.erase_mask = (4'h1 << blk) & ~r.guard;
              end
            end
            fcs_pkg::FCS_G6: begin
              if (pat == `FCS_PAT_55 && ((r.kind == fcs_pkg::FCS_K_GSET &&
                  code == `FCS_CODE_GSET) || (r.kind == fcs_pkg::FCS_K_GCLR &&
                  code == `FCS_CODE_GCLR))) begin
                next_r.state = fcs_pkg::FCS_G7;
              end
            end
            fcs_pkg::FCS_G7: begin
              next_r.op_cnt = OP_CYCLES[15:0];
              if (r.kind == fcs_pkg::FCS_K_GSET && code == `FCS_CODE_GSET) begin
                next_r.guard = r.guard | (4'h1 << sel2);
                next_r.state = fcs_pkg::FCS_BUSY;
              end else if (r.kind == fcs_pkg::FCS_K_GCLR && code == `FCS_CODE_GCLR) begin
                next_r.guard = adr_i[`FCS_SEL_MSB] ? (r.guard & 4'h3) : (r.guard & 4'hC);
                next_r.state = fcs_pkg::FCS_BUSY;
              end
            end
            default: next_r.state = fcs_pkg::FCS_READ;
          endcase
        end else if (req && !ctrl_hit && r.state != fcs_pkg::FCS_ID) begin
          // A load in mid-sequence returns array data and drops the sequence.
          next_r.state = fcs_pkg::FCS_READ;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs.
  assign dat_o = r.dat;
  assign ack_o = r.ack;
  assign array_addr_o = adr_i;
  assign prog_word_o = r.prog_word;
  assign prog_stb_o = r.prog_stb;
  assign busy_o = (r.state == fcs_pkg::FCS_BUSY);
  assign erase_mask_o = r.erase_mask;
  assign guard_o = r.guard;
  assign fail_i_unused_o = 1'b0;

  // ************************************************************
  // Checks.
  // ************************************************************
  a_busy_ignores: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && r.op_cnt != 16'h0 |=> busy_o) else $error("busy ended early");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_reset_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_C3 && code == `FCS_CODE_RESET |=>
    r.state == fcs_pkg::FCS_READ) else $error("read/reset failed");
  a_id_enter: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_C3 && code == `FCS_CODE_IDREAD && pat == `FCS_PAT_55
    |=> r.state == fcs_pkg::FCS_ID) else $error("id not entered");
  a_id_stay: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_ID && code == `FCS_CODE_IDSEL |=>
    r.state == fcs_pkg::FCS_ID && r.word_cnt == $past(sel2)) else $error("id left");
  a_prog_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_stb_o |-> prog_word_o == $past(dat_i)) else $error("program word wrong");
  a_guard_set: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_G7 && r.kind == fcs_pkg::FCS_K_GSET &&
    code == `FCS_CODE_GSET |=> guard_o[$past(sel2)] && busy_o) else $error("guard not set");
  a_guard_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_G7 && r.kind == fcs_pkg::FCS_K_GCLR &&
    code == `FCS_CODE_GCLR && !adr_i[15] |=> guard_o[1:0] == 2'h0) else $error("pair kept");
  a_mismatch: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_C2 && code != `FCS_CODE_UNLOCK2 |=>
    r.state == fcs_pkg::FCS_READ) else $error("mismatch kept");
  a_erase_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_mask_o != 4'h0 |-> busy_o) else $error("erase without busy");

  // ************************************************************
  // Checks of outputs and of the sequencer state against the command rules.
  // ************************************************************
  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held");
  a_busy_end: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && r.op_cnt == 16'h0 |=> !busy_o) else $error("busy stuck");
  a_busy_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o |=> $stable(guard_o)) else $error("guard changed while busy");
  a_chip_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_E6 && code == `FCS_CODE_CHIP && pat == `FCS_PAT_55
    |=> erase_mask_o == ~guard_o) else $error("chip erase mask wrong");
  a_block_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_E6 && code == `FCS_CODE_BLOCK && in_array
    |=> erase_mask_o == ((4'h1 << $past(blk)) & ~guard_o)) else $error("block mask wrong");
  a_id_maker: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && !ctrl_hit && r.state == fcs_pkg::FCS_ID && r.word_cnt == `FCS_ID_MAKER
    |=> dat_o == {24'h0, MAKER_CODE}) else $error("maker code wrong");
  a_prog_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_PROG && r.guard[blk]
    |=> !prog_stb_o) else $error("guarded block programmed");
  a_array_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && !ctrl_hit && r.state != fcs_pkg::FCS_ID
    |=> dat_o == $past(array_data_i)) else $error("array data wrong");
  a_status_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && ctrl_hit
    |=> dat_o[`FCS_RDY_BIT] == !$past(busy_o)) else $error("ready flag wrong");
  a_pair_high: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_G7 && r.kind == fcs_pkg::FCS_K_GCLR &&
    code == `FCS_CODE_GCLR && adr_i[15] |=> guard_o[3:2] == 2'h0) else $error("high pair kept");
  a_id_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_ID && code != `FCS_CODE_IDSEL &&
    !(code == `FCS_CODE_UNLOCK1 && pat == `FCS_PAT_55) |=> r.state == fcs_pkg::FCS_READ)
    else $error("identity mode kept");
  a_mask_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_mask_o != 4'h0 |=> erase_mask_o == 4'h0) else $error("erase mask held");
  a_prog_last: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_stb_o && r.word_cnt == 2'h0 |-> busy_o) else $error("fourth word not final");
  a_unlock_first: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && r.state == fcs_pkg::FCS_READ && code == `FCS_CODE_UNLOCK1 && pat == `FCS_PAT_55
    |=> r.state == fcs_pkg::FCS_C2) else $error("unlock not taken");
endmodule

// >>> rtl/fcs_params.svh
// Constants of the flash command sequencer.
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_CODE_UNLOCK1 8'hAA
`define FCS_CODE_UNLOCK2 8'h55
`define FCS_CODE_RESET 8'hF0
`define FCS_CODE_IDREAD 8'h90
`define FCS_CODE_IDSEL 8'h00
`define FCS_CODE_PROG 8'hA0
`define FCS_CODE_ERASE 8'h80
`define FCS_CODE_CHIP 8'h10
`define FCS_CODE_BLOCK 8'h30
`define FCS_CODE_GSET 8'h9A
`define FCS_CODE_GCLR 8'h6A
`define FCS_PAT_55 8'h55
`define FCS_PAT_AA 8'hAA
`define FCS_ARRAY_BASE 32'hBFC00000
`define FCS_BLK_LSB 17
`define FCS_SEL_MSB 15
`define FCS_SEL_LSB 14
`define FCS_PAT_MSB 15
`define FCS_PAT_LSB 8
`define FCS_ID_MAKER 2'h0
`define FCS_ID_PART 2'h1
`define FCS_ID_MACRO 2'h3
`define FCS_CTRL_ADDR 32'hFFFF0000
`define FCS_RDY_BIT 0
`define FCS_GUARD_LSB 4
`define FCS_OP_NS 1000
`define FCS_CLK_NS 10
`define FCS_OP_CYC (`FCS_OP_NS / `FCS_CLK_NS)
`endif

// >>> rtl/fcs_pkg.sv
// Types of the flash command sequencer.
package fcs_pkg;
  typedef enum logic [3:0] {
    FCS_READ, FCS_C2, FCS_C3, FCS_ID, FCS_PROG, FCS_E4, FCS_E5, FCS_E6,
    FCS_G4, FCS_G5, FCS_G6, FCS_G7, FCS_BUSY
  } fcs_state_t;
  typedef enum logic [1:0] {FCS_K_ERASE, FCS_K_GSET, FCS_K_GCLR} fcs_kind_t;
  typedef struct packed {
    fcs_state_t state;
    fcs_kind_t kind;
    logic [1:0] word_cnt;
    logic [3:0] guard;
    logic [3:0] erase_mask;
    logic [15:0] op_cnt;
    logic ack;
    logic [31:0] dat;
    logic [31:0] prog_word;
    logic prog_stb;
  } fcs_reg_t;
endpackage

// >>> sim/fcs_cpu_model.sv
// Bus master model that stands in for the CPU core.
`timescale 1ns/1ps
module fcs_cpu_model (
  // Clock.
  input wire logic clk_i,
  // Wishbone master side.
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [31:0] adr_o,
  output logic [31:0] dat_o,
  input wire logic ack_i
);
  localparam int GAP = 15; // One spacing, tuned once, serves every sequence.
  // The bus is idle at time zero.
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 32'h0;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [31:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= wr;
    adr_o <= {adr[31:2], 2'b00};
    dat_o <= dat;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr; // Released lines must not keep the old value.
    dat_o <= ~dat;
  endtask
  task automatic cmd(input logic [31:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
    repeat (GAP) @(posedge clk_i);
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the flash command sequencer.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] MK = 8'h3C; // Value is arbitrary.
  localparam logic [7:0] PK = 8'hC3; // Value is arbitrary.
  localparam logic [7:0] CK = 8'h5E; // Value is arbitrary.
  localparam logic [31:0] ST = 32'hFFFF0000;
  localparam logic [31:0] IDS [4] = '{{24'h0, MK}, {24'h0, PK}, 32'h0, {24'h0, CK}};
  logic clk_i, rst_i, cyc, stb, we, ack, prog_stb, busy;
  logic [31:0] adr, wdat, rdat, arr, pword, v;
  logic [3:0] emask, grd;
  logic fl;
  logic [31:0] aad;
  logic [31:0] seed = 32'h0000C1C8;
  logic [31:0] rdq[$];
  logic [31:0] pwq[$];
  logic [3:0] emq[$];
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // The clock toggles every half period.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  fcs_sequencer #(.MAKER_CODE(MK), .PART_CODE(PK), .MACRO_CODE(CK), .OP_CYCLES(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .array_data_i(arr),
    .array_addr_o(aad), .prog_word_o(pword), .prog_stb_o(prog_stb), .busy_o(busy),
    .erase_mask_o(emask), .guard_o(grd), .fail_i_unused_o(fl));
  fcs_cpu_model cpu (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .dat_o(wdat), .ack_i(ack));
  // Xorshift source of random values.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Sends a code at a pattern; upper data bits are noise.
  task automatic w(input logic [15:0] pat, input logic [7:0] code);
    logic [31:0] r;
    r = xs();
    cpu.cmd({16'hBFC0, pat}, {r[31:8], code});
  endtask
  // Sends the unlock pair and a third-cycle code.
  task automatic unl(input logic [7:0] code);
    w(16'h5500, 8'hAA);
    w(16'hAA00, 8'h55);
    w(16'h5500, code);
  endtask
  // Sends the five-write preamble of erase and guard commands.
  task automatic pre(input logic [7:0] code);
    unl(code);
    w(16'h5500, 8'hAA);
    w(16'hAA00, 8'h55);
  endtask
  // Notes the expected read data and issues the load.
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    cpu.xfer(1'b0, a, 32'h0);
  endtask
  // Last write of an automatic operation, then watch busy rise and fall.
  task automatic fin(input logic [31:0] a, input logic [31:0] d);
    logic saw;
    saw = 1'b0;
    cpu.xfer(1'b1, a, d);
    repeat (40) begin
      @(posedge clk_i);
      saw = saw | (busy === 1'b1);
    end
    chk({31'h0, saw}, 32'h1);
    chk({31'h0, busy}, 32'h0);
  endtask
  // Read data, program words and erase masks are compared with the oldest note of their kind; the array address with adr.
  always @(posedge clk_i) begin
    if (rst_i === 1'b0) begin
      if (ack === 1'b1 && we === 1'b0) begin
        chk(rdat, rdq.size() > 0 ? rdq.pop_front() : 32'hX);
      end
      if (ack === 1'b1) begin
        chk(aad, adr);
      end
      if (prog_stb === 1'b1) begin
        chk(pword, pwq.size() > 0 ? pwq.pop_front() : 32'hX);
      end
      if (emask !== 4'h0) begin
        chk({28'h0, emask}, emq.size() > 0 ? {28'h0, emq.pop_front()} : 32'hX);
      end
    end
  end
  // A hung run is cut short and counted as a mismatch.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Main sequence of scenarios.
  initial begin
    rst_i = 1'b1;
    arr = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ST, 32'h1);
    unl(8'h90);
    for (int i = 0; i < 4; i++) begin
      w({i[1:0], 14'h0}, 8'h00);
      rd(32'hBFC00200, IDS[i]);
    end
    unl(8'hF0);
    v = xs();
    arr <= v;
    rd(32'hBFC00400, v);
    unl(8'hA0);
    for (int i = 0; i < 4; i++) begin
      v = xs();
      pwq.push_back(v);
      if (i < 3) cpu.cmd(32'hBFC20040 + i * 4, v);
      else fin(32'hBFC2004C, v);
    end
    pre(8'h9A);
    w(16'h5500, 8'h9A);
    fin(32'hBFC08000, 32'h9A);
    chk({28'h0, grd}, 32'h4);
    rd(ST, 32'h41);
    pre(8'h80);
    emq.push_back(4'h2);
    v = xs();
    fin(32'hBFC20000 | (v & 32'h0001FFFC), 32'h30);
    // chip erase skips the guarded block
    pre(8'h80);
    emq.push_back(4'hB);
    fin(32'hBFC05500, 32'h10);
    // bit 15 clears the upper guard pair
    pre(8'h6A);
    w(16'h5500, 8'h6A);
    fin(32'hBFC0C000, 32'h6A);
    chk({28'h0, grd}, 32'h0);
    rd(ST, 32'h1);
    // a wrong code abandons the sequence
    w(16'h5500, 8'hAA);
    w(16'hAA00, 8'h12);
    w(16'h5500, 8'hA0);
    cpu.cmd(32'hBFC00000, xs());
    v = xs();
    arr <= v;
    rd(32'hBFC00800, v);
    repeat (4) @(posedge clk_i);
    chk(rdq.size() + pwq.size() + emq.size(), 32'h0);
    chk({31'h0, fl}, 32'h0);
    report_and_stop();
  end
endmodule
